// >>> core/acp_pkg.sv
// Purpose: shared constants and types of the amplifier control register port
// Assumes: 10 MHz system clock on both ends
// Notes: target registers 1..7, controller command registers 0..3
package acp_pkg;

  // ***************************************************
  // bus address and direction
  // ***************************************************
  localparam logic [6:0] TGT_ADDR = 7'h58;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // ***************************************************
  // target register map
  // ***************************************************
  localparam logic [7:0] REG_FIRST = 8'h01;
  localparam logic [7:0] REG_LAST = 8'h07;
  localparam logic [2:0] REG_FUNC = 3'h1;
  localparam logic [2:0] REG_ATTACK = 3'h2;
  localparam logic [2:0] REG_RELEASE = 3'h3;
  localparam logic [2:0] REG_HOLD = 3'h4;
  localparam logic [2:0] REG_GAIN = 3'h5;
  localparam logic [2:0] REG_LIMIT = 3'h6;
  localparam logic [2:0] REG_MAXG = 3'h7;
  // function control field positions
  localparam int FC_RIGHT_EN = 7;
  localparam int FC_LEFT_EN = 6;
  localparam int FC_SOFT_SD = 5;
  localparam int FC_FAULT_R = 4;
  localparam int FC_FAULT_L = 3;
  localparam int FC_THERMAL = 2;
  localparam int FC_NOISE_GATE_ENABLE = 0;
  // values after reset, index = register number, entry 0 unused
  localparam logic [7:0][7:0] REG_DEFAULTS = {
    8'hc0, 8'h19, 8'h12, 8'h0f, 8'h06, 8'h01, 8'hc2, 8'h00};
  // bits that a write stores directly
  localparam logic [7:0][7:0] WR_MASK = {
    8'hf3, 8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'he1, 8'h00};
  // bits that hardware sets and a written zero clears
  localparam logic [7:0][7:0] FLAG_MASK = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1c, 8'h00};
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ***************************************************
  // controller command registers
  // ***************************************************
  localparam logic [3:0] CR_CTRL = 4'h0;
  localparam logic [3:0] CR_PTR = 4'h1;
  localparam logic [3:0] CR_DATA = 4'h2;
  localparam logic [3:0] CR_STATUS = 4'h3;
  localparam int CTRL_GO = 0;
  localparam int CTRL_READ = 1;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 10000;
  localparam logic [4:0] QUARTER_CYC = 5'(SCL_PERIOD_NS / (4 * CLK_PERIOD_NS));

  // ***************************************************
  // state types
  // ***************************************************
  typedef enum logic [3:0] {
    T_IDLE = 4'b0000, T_ADDR = 4'b0001, T_ADDR_ACK = 4'b0010, T_REG = 4'b0011,
    T_REG_ACK = 4'b0100, T_WDATA = 4'b0101, T_WDATA_ACK = 4'b0110,
    T_RDATA = 4'b0111, T_RDATA_ACK = 4'b1000, T_IGNORE = 4'b1001
  } acp_tgt_e;

  typedef enum logic [2:0] {
    C_IDLE = 3'b000, C_START = 3'b001, C_BYTE = 3'b010, C_STOP = 3'b011,
    C_WAIT = 3'b100
  } acp_ctl_e;

  typedef enum logic [2:0] {
    K_ADDRW = 3'b000, K_REG = 3'b001, K_WDATA = 3'b010, K_ADDRR = 3'b011,
    K_RDATA = 3'b100
  } acp_kind_e;

endpackage : acp_pkg

// >>> core/acp_link_if.sv
// Purpose: open-drain two-wire link between controller and target
// Assumes: pull-ups, so a released line reads high
// Notes: wire levels are resolved here from the enables
`timescale 1ns/10ps
`default_nettype none
interface acp_link_if;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic tgt_sda_o;
  logic tgt_sda_oe;
  logic scl;
  logic sda;

  // wired-and of every enabled low driver
  assign scl = ~(ctl_scl_oe & ~ctl_scl_o);
  assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (tgt_sda_oe & ~tgt_sda_o));

  modport controller(output ctl_scl_o, ctl_scl_oe, ctl_sda_o, ctl_sda_oe, input sda);
  modport target(output tgt_sda_o, tgt_sda_oe, input scl, sda);
endinterface : acp_link_if
`default_nettype wire

// >>> core/acp_controller.sv
// Purpose: bus controller end, driven by software through command registers
// Assumes: target never stretches the clock
// Notes: scl made by a divider of clk, about 100 kHz
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module acp_controller import acp_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // command port
  input wire logic [3:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [7:0] cfg_rdata,
  // link
  acp_link_if.controller link
);

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    logic [1:0] sda_s;
    acp_ctl_e st;
    acp_kind_e kind;
    logic [1:0] ph;
    logic [4:0] div;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [3:0] left;
    logic rd;
    logic restart;
    logic nack;
    logic ackbit;
    logic scl_oe;
    logic sda_oe;
    logic [7:0] rdata;
  } acp_ctl_s;

  acp_ctl_s r, n;
  logic tick;
  logic go;

  always_comb begin
    n = r;
    go = 1'b0;
    tick = (r.div == QUARTER_CYC - 5'd1);
    n.sda_s = {r.sda_s[0], link.sda};
    n.div = (tick || r.st == C_IDLE || r.st == C_WAIT) ? 5'd0 : r.div + 5'd1;
    if (tick && r.st != C_IDLE && r.st != C_WAIT) begin
      n.ph = r.ph + 2'd1;
    end
    n.rdata = 8'h00;
    // register reads, data valid the cycle after the strobe only
    if (cfg_rd) begin
      if (cfg_addr == CR_CTRL) begin
        n.rdata = {r.left, 2'b00, r.rd, 1'b0};
      end else if (cfg_addr == CR_PTR) begin
        n.rdata = r.ptr;
      end else if (cfg_addr == CR_DATA) begin
        n.rdata = r.rx;
      end else if (cfg_addr == CR_STATUS) begin
        n.rdata = {5'b00000, r.st == C_WAIT, r.nack, r.st != C_IDLE};
      end
    end
    // register writes
    if (cfg_wr) begin
      if (cfg_addr == CR_CTRL && r.st == C_IDLE && cfg_wdata[CTRL_GO]) begin
        n.st = C_START;
        n.ph = 2'd0;
        n.rd = cfg_wdata[CTRL_READ];
        n.left = cfg_wdata[7:4];
        n.restart = 1'b0;
        n.nack = 1'b0;
        n.sda_oe = 1'b0;
      end else if (cfg_addr == CR_PTR) begin
        n.ptr = cfg_wdata;
      end else if (cfg_addr == CR_DATA) begin
        n.tx = cfg_wdata;
      end
    end
    // software supplying or taking a byte resumes a paused transfer
    if (r.st == C_WAIT) begin
      if (cfg_wr && cfg_addr == CR_DATA && !r.rd) begin
        n.shift = cfg_wdata;
        n.kind = K_WDATA;
        go = 1'b1;
      end else if (cfg_rd && cfg_addr == CR_DATA && r.rd) begin
        n.kind = K_RDATA;
        go = 1'b1;
      end
    end
    if (tick) begin
      case (r.st)
        C_START: begin
          // release sda, raise scl, then pull sda low while scl is high
          if (r.ph == 2'd0) begin
            n.scl_oe = 1'b0;
          end else if (r.ph == 2'd1) begin
            n.sda_oe = 1'b1;
          end else if (r.ph == 2'd2) begin
            n.scl_oe = 1'b1;
          end else begin
            n.kind = r.restart ? K_ADDRR : K_ADDRW;
            n.shift = {TGT_ADDR, r.restart ? DIR_READ : DIR_WRITE};
            go = 1'b1;
          end
        end
        C_BYTE: begin
          if (r.ph == 2'd0) begin
            n.scl_oe = 1'b0;
          end else if (r.ph == 2'd2) begin
            n.scl_oe = 1'b1;
            if (r.bitn == 4'd8) begin
              n.ackbit = ~r.sda_s[1];
            end else begin
              n.shift = {r.shift[6:0], r.sda_s[1]};
            end
          end else if (r.ph == 2'd3) begin
            n.bitn = r.bitn + 4'd1;
            if (r.bitn == 4'd7) begin
              // ninth bit: acknowledge all read bytes but the last
              n.sda_oe = (r.kind == K_RDATA) && (r.left != 4'd0);
            end else if (r.bitn == 4'd8) begin
              n.sda_oe = 1'b0;
              n.st = C_STOP;
              case (r.kind)
                K_ADDRW: begin
                  if (r.ackbit) begin
                    n.kind = K_REG;
                    n.shift = r.ptr;
                    go = 1'b1;
                  end
                end
                K_REG: begin
                  if (r.ackbit && r.rd) begin
                    n.st = C_START;
                    n.restart = 1'b1;
                  end else if (r.ackbit) begin
                    n.kind = K_WDATA;
                    n.shift = r.tx;
                    go = 1'b1;
                  end
                end
                K_WDATA: begin
                  if (r.ackbit && r.left != 4'd0) begin
                    n.left = r.left - 4'd1;
                    n.st = C_WAIT;
                  end
                end
                K_ADDRR: begin
                  if (r.ackbit) begin
                    n.kind = K_RDATA;
                    go = 1'b1;
                  end
                end
                default: begin
                  n.rx = r.shift;
                  if (r.left != 4'd0) begin
                    n.left = r.left - 4'd1;
                    n.st = C_WAIT;
                  end
                end
              endcase
              if (!r.ackbit && r.kind != K_RDATA) begin
                n.nack = 1'b1;
              end
              if (n.st == C_STOP) begin
                n.sda_oe = 1'b1; // stop begins with sda low, scl low
              end
            end else begin
              n.sda_oe = (r.kind != K_RDATA) && !r.shift[7];
            end
          end
        end
        C_STOP: begin
          // raise scl, then release sda while scl is high
          if (r.ph == 2'd0) begin
            n.scl_oe = 1'b0;
          end else if (r.ph == 2'd1) begin
            n.sda_oe = 1'b0;
          end else if (r.ph == 2'd3) begin
            n.st = C_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
    // start of a byte: first bit placed while scl is low
    if (go) begin
      n.st = C_BYTE;
      n.ph = 2'd0;
      n.div = 5'd0;
      n.bitn = 4'd0;
      n.sda_oe = (n.kind != K_RDATA) && !n.shift[7];
    end
  end

  // registered state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{sda_s: 2'b11, st: C_IDLE, kind: K_ADDRW, default: '0};
    end else begin
      r <= n;
    end
  end

  assign cfg_rdata = r.rdata;
  assign link.ctl_scl_o = 1'b0;
  assign link.ctl_sda_o = 1'b0;
  assign link.ctl_scl_oe = r.scl_oe;
  assign link.ctl_sda_oe = r.sda_oe;

endmodule : acp_controller
`default_nettype wire

// >>> core/acp_target.sv
// Purpose: target end holding the seven amplifier control registers
// Assumes: scl slow against clk, at least four clk periods per half bit
// Notes: all link pins and analog event inputs pass two flip-flops
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - write opens with start, address, direction zero
// - register select byte follows and is acknowledged
// - data byte stored, acknowledged, then stop
// - any number of write data bytes acknowledged
// - sequential writes go to next higher register
// - read: register byte, repeated start, direction one
// - selected register sent most significant bit first
// - controller ends read with nack and stop
// - bytes keep coming while the controller acknowledges
// - read pointer advances after every delivered byte
// - fixed address bytes b0 write, b1 read
// - function control register bit layout
// - fault flags stick until written zero
// - registers two to five hold six bits
// - register six: limiter, gate threshold, level
// - register seven: max gain and ratio
// - reset defaults for registers one to seven
// - shutdown pin low restores all defaults
// - controller keeps off reserved test registers
module acp_target import acp_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins and analog events
  input wire logic shutdown_pin_n,
  input wire logic over_current_right,
  input wire logic over_current_left,
  input wire logic over_temperature,
  // function control outputs
  output logic right_channel_enable,
  output logic left_channel_enable,
  output logic soft_shutdown,
  output logic fault_right,
  output logic fault_left,
  output logic thermal_flag,
  output logic noise_gate_enable,
  // timing and gain outputs
  output logic [5:0] attack_duration,
  output logic [5:0] release_duration,
  output logic [5:0] hold_duration,
  output logic [5:0] base_gain,
  output logic limiter_disable,
  output logic [1:0] gate_threshold,
  output logic [4:0] limiter_level,
  output logic [3:0] max_gain,
  output logic [1:0] compression_ratio,
  // link
  acp_link_if.target link
);

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] sdz_s;
    logic [1:0][2:0] ev_s;
    acp_tgt_e st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rd;
    logic sda_oe;
    logic [7:0][7:0] regs;
  } acp_tgt_s;

  acp_tgt_s r, n;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [2:0] idx;
  logic [7:0] rd_val;

  // ***************************************************
  // link decoding and register file
  // ***************************************************
  // the first stage of each synchroniser feeds only the second
  always_comb begin
    n = r;
    n.scl_s = {r.scl_s[1:0], link.scl};
    n.sda_s = {r.sda_s[1:0], link.sda};
    n.sdz_s = {r.sdz_s[0], shutdown_pin_n};
    n.ev_s[0] = {over_temperature, over_current_left, over_current_right};
    n.ev_s[1] = r.ev_s[0];
    rise = r.scl_s[1] && !r.scl_s[2];
    fall = !r.scl_s[1] && r.scl_s[2];
    // sda moves only while scl is low, except for start and stop
    start = r.scl_s[1] && r.scl_s[2] && !r.sda_s[1] && r.sda_s[2];
    stop = r.scl_s[1] && r.scl_s[2] && r.sda_s[1] && !r.sda_s[2];
    idx = r.ptr[2:0];
    // reserved and unused locations read as a fixed value
    rd_val = (r.ptr >= REG_FIRST && r.ptr <= REG_LAST) ? r.regs[idx] : READ_UNMAPPED;
    case (r.st)
      T_ADDR, T_REG, T_WDATA: begin
        if (rise) begin
          n.shift = {r.shift[6:0], r.sda_s[1]};
          n.cnt = r.cnt + 4'd1;
        end else if (fall && r.cnt == 4'd8) begin
          n.cnt = 4'd0;
          if (r.st == T_ADDR) begin
            if (r.shift[7:1] == TGT_ADDR) begin
              n.sda_oe = 1'b1;
              n.rd = (r.shift[0] == DIR_READ);
              n.st = T_ADDR_ACK;
            end else begin
              n.st = T_IGNORE;
            end
          end else if (r.st == T_REG) begin
            n.ptr = r.shift;
            n.sda_oe = 1'b1;
            n.st = T_REG_ACK;
          end else begin
            // writes outside 1..7 are dropped but still acknowledged
            if (r.ptr >= REG_FIRST && r.ptr <= REG_LAST) begin
              n.regs[idx] = ((r.regs[idx] & ~WR_MASK[idx]) | (r.shift & WR_MASK[idx]))
                & ~(FLAG_MASK[idx] & ~r.shift);
            end
            n.ptr = r.ptr + 8'h01;
            n.sda_oe = 1'b1;
            n.st = T_WDATA_ACK;
          end
        end
      end
      T_ADDR_ACK, T_REG_ACK, T_WDATA_ACK: begin
        if (fall) begin
          n.sda_oe = 1'b0;
          n.cnt = 4'd0;
          if (r.st == T_ADDR_ACK && r.rd) begin
            n.shift = rd_val;
            n.sda_oe = !rd_val[7];
            n.st = T_RDATA;
          end else if (r.st == T_ADDR_ACK) begin
            n.st = T_REG;
          end else begin
            n.st = T_WDATA;
          end
        end
      end
      T_RDATA: begin
        if (rise) begin
          n.cnt = r.cnt + 4'd1;
        end else if (fall && r.cnt == 4'd8) begin
          n.sda_oe = 1'b0;
          n.ptr = r.ptr + 8'h01;
          n.st = T_RDATA_ACK;
        end else if (fall) begin
          n.shift = {r.shift[6:0], 1'b0};
          n.sda_oe = !r.shift[6];
        end
      end
      T_RDATA_ACK: begin
        if (rise) begin
          n.shift = {r.shift[6:0], r.sda_s[1]};
        end else if (fall && !r.shift[0]) begin
          n.cnt = 4'd0;
          n.shift = rd_val;
          n.sda_oe = !rd_val[7];
          n.st = T_RDATA;
        end else if (fall) begin
          n.st = T_IGNORE;
        end
      end
      default: begin
      end
    endcase
    // start or stop end any transfer in progress
    if (start) begin
      n.st = T_ADDR;
      n.cnt = 4'd0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.st = T_IDLE;
      n.sda_oe = 1'b0;
    end
    // events set after the write so a set in the clearing cycle wins
    n.regs[REG_FUNC][FC_FAULT_R] = n.regs[REG_FUNC][FC_FAULT_R] | r.ev_s[1][0];
    n.regs[REG_FUNC][FC_FAULT_L] = n.regs[REG_FUNC][FC_FAULT_L] | r.ev_s[1][1];
    n.regs[REG_FUNC][FC_THERMAL] = n.regs[REG_FUNC][FC_THERMAL] | r.ev_s[1][2];
    // shutdown pin low holds everything at defaults, events included
    if (!r.sdz_s[1]) begin
      n.regs = REG_DEFAULTS;
      n.st = T_IDLE;
      n.sda_oe = 1'b0;
      n.ptr = 8'h00;
    end
  end

  // registered state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{scl_s: 3'b111, sda_s: 3'b111, sdz_s: 2'b00, ev_s: '0, st: T_IDLE,
        regs: REG_DEFAULTS, default: '0};
    end else begin
      r <= n;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  // field views of the register flops
  assign right_channel_enable = r.regs[REG_FUNC][FC_RIGHT_EN];
  assign left_channel_enable = r.regs[REG_FUNC][FC_LEFT_EN];
  assign soft_shutdown = r.regs[REG_FUNC][FC_SOFT_SD];
  assign fault_right = r.regs[REG_FUNC][FC_FAULT_R];
  assign fault_left = r.regs[REG_FUNC][FC_FAULT_L];
  assign thermal_flag = r.regs[REG_FUNC][FC_THERMAL];
  assign noise_gate_enable = r.regs[REG_FUNC][FC_NOISE_GATE_ENABLE];
  assign attack_duration = r.regs[REG_ATTACK][5:0];
  assign release_duration = r.regs[REG_RELEASE][5:0];
  assign hold_duration = r.regs[REG_HOLD][5:0];
  assign base_gain = r.regs[REG_GAIN][5:0];
  assign limiter_disable = r.regs[REG_LIMIT][7];
  assign gate_threshold = r.regs[REG_LIMIT][6:5];
  assign limiter_level = r.regs[REG_LIMIT][4:0];
  assign max_gain = r.regs[REG_MAXG][7:4];
  assign compression_ratio = r.regs[REG_MAXG][1:0];
  // open drain: output value low, enable says when
  assign link.tgt_sda_o = 1'b0;
  assign link.tgt_sda_oe = r.sda_oe;

endmodule : acp_target
`default_nettype wire

// >>> verification/acp_link_properties.sv
// Purpose: link properties between controller and target ends
// Assumes: both ends share one link with pull-ups on scl and sda
// Notes: framing is tracked here to know who owns each ack slot
`timescale 1ns/10ps
`default_nettype none
module acp_link_properties import acp_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // data line drivers
  input wire logic ctl_sda_oe,
  input wire logic tgt_sda_oe,
  // resolved wires
  input wire logic scl,
  input wire logic sda
);
  // ****************
  // framing tracker
  // ****************
  logic scl_r, sda_r, first_r, live_r, rd_r;
  logic [3:0] nbit_r;
  logic [6:0] shf_r;
  wire logic ack_w = scl && !scl_r && nbit_r == 4'h8; // ninth rise of a byte
  // a start clears the count; the eighth address rise decides the match
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {scl_r, sda_r, first_r, live_r, rd_r} <= 5'b11000;
      nbit_r <= 4'h0;
      shf_r <= 7'h00;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      if (scl && scl_r && sda_r && !sda) begin
        nbit_r <= 4'h0;
        first_r <= 1'b1;
        live_r <= 1'b0;
      end else if (scl && scl_r && !sda_r && sda) begin
        first_r <= 1'b0;
        live_r <= 1'b0;
      end else if (scl && !scl_r) begin
        nbit_r <= ack_w ? 4'h0 : nbit_r + 4'h1;
        shf_r <= {shf_r[5:0], sda};
        if (ack_w) first_r <= 1'b0;
        if (first_r && nbit_r == 4'h7) begin
          live_r <= shf_r == TGT_ADDR;
          rd_r <= sda;
        end
      end
    end
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_start;
    scl && sda ##1 scl && !sda;
  endsequence
  sequence s_stop;
    scl && !sda ##1 scl && sda;
  endsequence
  property p_start_hold;
    s_start |=> scl [*8];
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("scl low soon after start");
  property p_stop_idle;
    s_stop |=> (scl && sda) [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("bus busy soon after stop");
  property p_tgt_low;
    $changed(tgt_sda_oe) |-> !scl;
  endproperty
  a_tgt_low: assert property (p_tgt_low) else $error("target moved sda with scl high");
  property p_ctl_cond;
    (scl && scl_r && sda != sda_r) |-> ctl_sda_oe != $past(ctl_sda_oe);
  endproperty
  a_ctl_cond: assert property (p_ctl_cond) else $error("sda moved in high phase");
  property p_contend;
    tgt_sda_oe && ctl_sda_oe |-> !scl;
  endproperty
  a_contend: assert property (p_contend) else $error("both pull sda with scl high");
  property p_ack_addr;
    ack_w && first_r && live_r |-> tgt_sda_oe;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("own address not acked");
  property p_ack_write;
    ack_w && !first_r && live_r && !rd_r |-> tgt_sda_oe;
  endproperty
  a_ack_write: assert property (p_ack_write) else $error("written byte not acked");
  property p_rel_read;
    ack_w && !first_r && live_r && rd_r |-> !tgt_sda_oe [*4];
  endproperty
  a_rel_read: assert property (p_rel_read) else $error("target held read ack slot");
endmodule : acp_link_properties
`default_nettype wire

// >>> verification/acp_tb_top.sv
// Purpose: self-checking bench of both ends of the register port
// Assumes: command port and timing as handed over by the designer
// Notes: a second link with a bench-made 800 ns clock probes address filtering
`timescale 1ns/10ps
`default_nettype none
module acp_tb_top import acp_pkg::*; ();
  logic clk, sys_rst, cfg_wr, cfg_rd, shutdown_pin_n, oc_r, oc_l, ot, ack, lim_dis;
  logic [3:0] cfg_addr, mgain;
  logic [7:0] cfg_wdata, cfg_rdata;
  logic [6:0] fc;
  logic [5:0] att, rel, hld, gain;
  logic [1:0] gthr, ratio;
  logic [4:0] llev;
  logic [7:0] wbuf [2], rbuf [7];
  int n_fail = 0, checks = 0;
  // reset values; rows hold register, written value, value read back
  localparam logic [7:0] DFLT [7] = '{8'hc2, 8'h01, 8'h06, 8'h0f, 8'h12, 8'h19, 8'hc0};
  localparam logic [23:0] ROWS [7] = '{24'h01_3d23, 24'h02_ff3f, 24'h03_c505,
    24'h04_2a2a, 24'h05_4000, 24'h06_a7a7, 24'h07_5f53};
  acp_link_if link();
  acp_link_if link2();
  acp_controller i_acp_controller(.clk(clk), .sys_rst(sys_rst), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .link(link));
  acp_target i_acp_target(.clk(clk), .sys_rst(sys_rst), .shutdown_pin_n(shutdown_pin_n),
    .over_current_right(oc_r), .over_current_left(oc_l), .over_temperature(ot),
    .right_channel_enable(fc[6]), .left_channel_enable(fc[5]), .soft_shutdown(fc[4]),
    .fault_right(fc[3]), .fault_left(fc[2]), .thermal_flag(fc[1]), .noise_gate_enable(fc[0]),
    .attack_duration(att), .release_duration(rel), .hold_duration(hld), .base_gain(gain),
    .limiter_disable(lim_dis), .gate_threshold(gthr), .limiter_level(llev), .max_gain(mgain),
    .compression_ratio(ratio), .link(link));
  // probe end on the bench-driven link
  acp_target i_acp_target_probe(.clk(clk), .sys_rst(sys_rst), .shutdown_pin_n(shutdown_pin_n),
    .over_current_right(oc_r), .over_current_left(oc_l), .over_temperature(ot),
    .right_channel_enable(), .left_channel_enable(), .soft_shutdown(), .fault_right(),
    .fault_left(), .thermal_flag(), .noise_gate_enable(), .attack_duration(),
    .release_duration(), .hold_duration(), .base_gain(), .limiter_disable(),
    .gate_threshold(), .limiter_level(), .max_gain(), .compression_ratio(), .link(link2));
  acp_link_properties i_acp_link_properties(.clk(clk), .sys_rst(sys_rst),
    .ctl_sda_oe(link.ctl_sda_oe), .tgt_sda_oe(link.tgt_sda_oe), .scl(link.scl), .sda(link.sda));
  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic cw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask : cw
  // read data stand only in the cycle after the strobe
  task automatic cr(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1 d = cfg_rdata;
  endtask : cr
  task automatic wait_st(input int b, input logic v);
    logic [7:0] s;
    for (int i = 0; i < 4000; i++) begin
      cr(CR_STATUS, s);
      if (s[b] === v) return;
    end
    n_fail++;
    complete_run();
  endtask : wait_st
  task automatic wr_regs(input logic [7:0] p, input int n);
    logic [7:0] s;
    cw(CR_PTR, p);
    cw(CR_DATA, wbuf[0]);
    cw(CR_CTRL, {4'(n - 1), 4'h1});
    for (int i = 1; i < n; i++) begin
      wait_st(2, 1'b1);
      cw(CR_DATA, wbuf[i]);
    end
    wait_st(0, 1'b0);
    cr(CR_STATUS, s);
    chk(s & 8'h02, 8'h00);
  endtask : wr_regs
  // the last byte is answered with a nack, so no pause before it ends
  task automatic rd_regs(input logic [7:0] p, input int n);
    cw(CR_PTR, p);
    cw(CR_CTRL, {4'(n - 1), 4'h3});
    for (int i = 0; i < n; i++) begin
      wait_st((i < n - 1) ? 2 : 0, i < n - 1);
      cr(CR_DATA, rbuf[i]);
    end
  endtask : rd_regs
  task automatic dflt_chk();
    rd_regs(8'h01, 7);
    foreach (DFLT[i]) chk(rbuf[i], DFLT[i]);
  endtask : dflt_chk
  // bench link: high means pull low; each step lasts n clocks
  task automatic bb_step(input logic scl_lo, input logic sda_lo, input int n);
    @(posedge clk);
    link2.ctl_scl_oe <= scl_lo;
    link2.ctl_sda_oe <= sda_lo;
    repeat (n - 1) @(posedge clk);
  endtask : bb_step
  task automatic bb_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bb_step(1'b1, link2.ctl_sda_oe, 2);
      bb_step(1'b1, ~d[i], 2);
      bb_step(1'b0, ~d[i], 4);
    end
    bb_step(1'b1, link2.ctl_sda_oe, 2);
    bb_step(1'b1, 1'b0, 2);
    bb_step(1'b0, 1'b0, 2);
    #1 ack = link2.tgt_sda_oe;
    bb_step(1'b0, 1'b0, 2);
  endtask : bb_byte
  // ****************
  // main sequence
  // ****************
  initial begin
    {sys_rst, shutdown_pin_n, cfg_wr, cfg_rd, oc_r, oc_l, ot} = 7'h60;
    cfg_addr = 4'h0;
    cfg_wdata = 8'h00;
    {link2.ctl_scl_o, link2.ctl_scl_oe, link2.ctl_sda_o, link2.ctl_sda_oe} = 4'h0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    dflt_chk();
    foreach (ROWS[i]) begin
      wbuf[0] = ROWS[i][15:8];
      wr_regs(ROWS[i][23:16], 1);
    end
    rd_regs(8'h01, 7);
    foreach (ROWS[i]) chk(rbuf[i], ROWS[i][7:0]);
    chk({lim_dis, gthr, llev}, 8'ha7);
    chk({mgain, 2'b00, ratio}, 8'h53);
    chk({2'b00, att}, 8'h3f);
    chk({2'b00, rel}, 8'h05);
    chk({2'b00, hld}, 8'h2a);
    chk({2'b00, gain}, 8'h00);
    // two bytes from register 6 land in 6 and 7
    wbuf = '{8'h11, 8'hf6};
    wr_regs(8'h06, 2);
    rd_regs(8'h06, 2);
    chk(rbuf[0], 8'h11);
    chk(rbuf[1], 8'hf2);
    // events latch until a zero is written; a one leaves the flag alone
    {oc_r, oc_l, ot} <= 3'b111;
    repeat (6) @(posedge clk);
    {oc_r, oc_l, ot} <= 3'b000;
    rd_regs(8'h01, 1);
    chk(rbuf[0], 8'h3f);
    wbuf[0] = 8'h34;
    wr_regs(8'h01, 1);
    chk({1'b0, fc}, 8'h1a);
    wbuf[0] = 8'h00;
    wr_regs(8'h01, 1);
    chk({1'b0, fc}, 8'h00);
    // shutdown pin low restores every default
    shutdown_pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    shutdown_pin_n <= 1'b1;
    repeat (5) @(posedge clk);
    dflt_chk();
    // foreign address first, then the documented write address byte
    for (int k = 0; k < 2; k++) begin
      bb_step(1'b0, 1'b1, 4);
      bb_byte(k ? 8'hb0 : 8'hb4);
      chk({7'h00, ack}, 8'(k));
      bb_step(1'b1, 1'b0, 2);
      bb_step(1'b1, 1'b1, 2);
      bb_step(1'b0, 1'b1, 4);
      bb_step(1'b0, 1'b0, 4);
    end
    complete_run();
  end
endmodule : acp_tb_top
`default_nettype wire
